//--- common/cptc_params.svh
// constants for the channel port transfer control block
`ifndef CPTC_PARAMS_SVH
`define CPTC_PARAMS_SVH
`define CPTC_REG_CMD      3'h0
`define CPTC_REG_ISTAT    3'h1
`define CPTC_REG_INBUF    3'h2
`define CPTC_REG_ATTN     3'h4
`define CPTC_REG_UFS      3'h5
`define CPTC_REG_DTYPE    3'h6
`define CPTC_REG_OUTBUF   3'h7
`define CPTC_CMD_WRITE    6'h31
`define CPTC_CMD_READ     6'h39
`define CPTC_CMD_ICLR     6'h09
`define CPTC_BIT_GO       0
`define CPTC_BIT_DRV_READY 7
`define CPTC_BIT_CYCLE    4
`define CPTC_BIT_READY    7
`define CPTC_BIT_DPE      13
`define CPTC_BIT_CPE      12
`define CPTC_BIT_ATTN     15
`define CPTC_DT_LINE      2
`define CPTC_CAPTURE_NS   250
`define CPTC_CLK_NS       100
`define CPTC_FIFO_DEPTH   4
`define CPTC_ZERO16       16'h0000
`endif

//--- common/cptc_pkg.sv
// types for the channel port transfer control block
package cptc_pkg;
  typedef enum logic [1:0] {
    CPTC_IDLE   = 2'b00,
    CPTC_BUSY   = 2'b01,
    CPTC_END    = 2'b10,
    CPTC_HUNG   = 2'b11
  } cptc_state_type;
  typedef logic [15:0] cptc_word_type;
endpackage

//--- rtl/cptc_fifo.sv
// small flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
module cptc_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;
  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule

//--- rtl/cptc_top.sv
// command decode and transfer handshake of the channel port interface unit
// What this block does
// - command bits 5..1 decoded; unknown codes start no cycle and leave busy low, with go held one.
// - go clears when a transfer ends, shown by run falling.
// - interface clear keeps go set and clear output high until next command.
// - every valid read or write command gives one go pulse.
// - ready status true while transfer enable control is low.
// - attention summary sets only the bit of our own select code.
// - control and data parity errors reported in interface status.
// - cycle flag set by either cycle request or software cycle bit 4.
// - new cycle starts only after previous completes, busy and ready low, run high.
// - busy asserted once per word or byte; its rise starts a cycle.
// - early cycle request is stored and starts next cycle at once.
// - cycle requests before a valid read or write command are ignored.
// - command 61 octal is write; host data strobed onto user lines.
// - command 71 octal is read; user data words accepted.
// - end cycle marks each transfer done and clears busy.
// - write data held until new word arrives, shown after end cycle.
// - busy sets after cycle request falls, only if previous done and not ready.
// - read data captured at the rise of busy.
// - function/status read gives eight control function bits and eight user inputs.
// - drive type select drives the fixed type code on control line 2.
// - command 11 octal is interface clear, same as bus initialisation except go and clear output set and command bits loaded.
// - bus initialisation resets control, status and input buffer; fifos and output buffer are kept.
`timescale 1ns/1ps
`include "cptc_params.svh"
module cptc_top #(
  parameter int          FIFO_DEPTH = `CPTC_FIFO_DEPTH,
  parameter logic [15:0] DRIVE_TYPE = 16'h0015  // arbitrary neutral type code
) (
  input  wire logic                   clk_sys,
  input  wire logic                   rst_n,
  input  wire logic                   bus_init,
  input  wire logic                   run,
  input  wire logic                   reg_write,
  input  wire logic                   reg_read,
  input  wire logic [2:0]             reg_addr,
  input  wire cptc_pkg::cptc_word_type reg_wdata,
  input  wire logic                   reg_wparity,
  output cptc_pkg::cptc_word_type     reg_rdata,
  output logic                        type_line,
  input  wire logic                   type_reg_select,
  input  wire logic                   wr_valid,
  output logic                        wr_ready,
  input  wire cptc_pkg::cptc_word_type wr_data,
  output logic                        rd_valid,
  input  wire logic                   rd_ready,
  output cptc_pkg::cptc_word_type     rd_data,
  input  wire logic [2:0]             unit_select_code,
  input  wire logic                   transfer_enable_ctl,
  input  wire logic                   cycle_req_a,
  input  wire logic                   cycle_req_b,
  input  wire cptc_pkg::cptc_word_type user_data_in,
  input  wire logic                   parity_in_low,
  input  wire logic                   parity_in_high,
  input  wire logic                   input_parity_inhibit,
  input  wire logic [3:0]             attention_lines,
  input  wire logic [7:0]             user_status_bits,
  input  wire logic                   user_error,
  output cptc_pkg::cptc_word_type     user_data_out,
  output logic                        parity_out_low,
  output logic                        parity_out_high,
  output logic [7:0]                  user_function_bits,
  output logic                        user_go,
  output logic                        user_read,
  output logic                        busy,
  output logic                        end_cycle,
  output logic                        iface_clear
);
  import cptc_pkg::*;

  function automatic logic odd_par(input logic [7:0] b);
    odd_par = ~(^b);
  endfunction

  function automatic logic addr_hit(input logic strobe, input logic [2:0] addr,
                                    input logic [2:0] want);
    addr_hit = strobe && (addr == want);
  endfunction

  // ==========================================================
  // reset and command decode
  // ==========================================================
  logic           srst;
  logic [5:0]     cmd;
  logic           go;
  logic           xfer_cmd;
  logic           hung;
  logic           run_d;
  logic           cmd_wr;
  logic           istat_wr;
  logic           cycle_sw;
  logic           cpe;
  logic           dpe;
  logic [7:0]     attn_bits;
  cptc_state_type state;
  cptc_word_type  in_buf;
  cptc_word_type  out_buf;
  logic           out_new;

  assign cmd_wr   = addr_hit(reg_write, reg_addr, `CPTC_REG_CMD);
  assign istat_wr = addr_hit(reg_write, reg_addr, `CPTC_REG_ISTAT);
  // interface clear is folded into the synchronous reset path
  assign srst = bus_init ||
                (cmd_wr && reg_wdata[5:0] == `CPTC_CMD_ICLR);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cmd         <= '0;
      go          <= 1'b0;
      xfer_cmd    <= 1'b0;
      hung        <= 1'b0;
      user_go     <= 1'b0;
      user_read   <= 1'b0;
      iface_clear <= 1'b0;
      run_d       <= 1'b0;
    end else begin
      run_d   <= run;
      user_go <= 1'b0;
      if (bus_init) begin
        cmd         <= '0;
        user_read   <= 1'b0;
        go          <= 1'b0;
        xfer_cmd    <= 1'b0;
        hung        <= 1'b0;
        iface_clear <= 1'b0;
      end else if (cmd_wr && reg_wdata[`CPTC_BIT_GO]) begin
        cmd         <= reg_wdata[5:0];
        go          <= 1'b1;
        iface_clear <= 1'b0;
        xfer_cmd    <= 1'b0;
        hung        <= 1'b0;
        case (reg_wdata[5:0])
          `CPTC_CMD_WRITE: begin
            xfer_cmd  <= 1'b1;
            user_read <= 1'b0;
            user_go   <= 1'b1;
          end
          `CPTC_CMD_READ: begin
            xfer_cmd  <= 1'b1;
            user_read <= 1'b1;
            user_go   <= 1'b1;
          end
          `CPTC_CMD_ICLR: begin
            iface_clear <= 1'b1;
            user_read   <= 1'b0;
          end
          default: begin
            hung <= 1'b1;
          end
        endcase
      end else if (xfer_cmd && run_d && !run) begin
        go       <= 1'b0;
        xfer_cmd <= 1'b0;
      end
    end
  end

  // ==========================================================
  // cycle request synchronisers and cycle flag
  // ==========================================================
  logic [1:0] req_s1;
  logic [1:0] req_s2;
  logic [1:0] req_s3;
  logic       req_fall;
  logic       cycle_pend;
  logic       start;
  logic       rd_in_ready;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      req_s1 <= '0;
      req_s2 <= '0;
      req_s3 <= '0;
    end else begin
      req_s1 <= {cycle_req_b, cycle_req_a};
      req_s2 <= req_s1;
      req_s3 <= req_s2;
    end
  end
  assign req_fall = |(req_s3 & ~req_s2);
  assign cycle_sw = istat_wr && reg_wdata[`CPTC_BIT_CYCLE];
  // ready must be low for a new cycle; run must still stand
  // a read also waits for fifo room, so a stored request is kept while the fifo is full
  assign start = cycle_pend && (state == CPTC_IDLE) && run && transfer_enable_ctl
                 && !busy && (!user_read || rd_in_ready);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cycle_pend <= 1'b0;
    end else if (srst || !xfer_cmd) begin
      cycle_pend <= 1'b0;
    end else if (req_fall || cycle_sw) begin
      cycle_pend <= 1'b1;
    end else if (start) begin
      cycle_pend <= 1'b0;
    end
  end

  // ==========================================================
  // transfer sequencer
  // ==========================================================
  logic fifo_out_valid;
  logic fifo_pop;
  cptc_word_type fifo_out;
  logic rd_push;

  assign fifo_pop = (state == CPTC_END) && !user_read && fifo_out_valid;
  assign rd_push  = (state == CPTC_IDLE) && start && user_read;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state     <= CPTC_IDLE;
      busy      <= 1'b0;
      end_cycle <= 1'b0;
    end else if (srst) begin
      state     <= CPTC_IDLE;
      busy      <= 1'b0;
      end_cycle <= 1'b0;
    end else begin
      case (state)
        CPTC_IDLE: begin
          if (start && (!user_read || rd_in_ready)) begin
            busy      <= 1'b1;
            end_cycle <= 1'b0;
            state     <= CPTC_BUSY;
          end
        end
        CPTC_BUSY: begin
          busy      <= 1'b0;
          end_cycle <= 1'b1;
          state     <= CPTC_END;
        end
        CPTC_END: begin
          state <= hung ? CPTC_HUNG : CPTC_IDLE;
        end
        CPTC_HUNG: begin
          state <= CPTC_HUNG;
        end
        default: begin
          state <= CPTC_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // data paths and parity
  // ==========================================================
  cptc_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_wr_fifo (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .in_valid  (wr_valid),
    .in_ready  (wr_ready),
    .in_data   (wr_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_out)
  );

  cptc_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_rd_fifo (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .in_valid  (rd_push && rd_in_ready),
    .in_ready  (rd_in_ready),
    .in_data   (user_data_in),
    .out_valid (rd_valid),
    .out_ready (rd_ready),
    .out_data  (rd_data)
  );

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      user_data_out   <= `CPTC_ZERO16;
      parity_out_low  <= 1'b0;
      parity_out_high <= 1'b0;
    end else if (fifo_pop || out_new) begin
      // old word stays on the lines until a new one is present
      user_data_out   <= fifo_pop ? fifo_out : out_buf;
      parity_out_low  <= odd_par(fifo_pop ? fifo_out[7:0] : out_buf[7:0]);
      parity_out_high <= odd_par(fifo_pop ? fifo_out[15:8] : out_buf[15:8]);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      in_buf <= `CPTC_ZERO16;
    end else if (srst) begin
      in_buf <= `CPTC_ZERO16;
    end else if (rd_push) begin
      in_buf <= user_data_in;
    end
  end

  // a fault that lands in the clearing cycle still latches, so none goes unseen
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dpe <= 1'b0;
    end else if (rd_push && !input_parity_inhibit &&
                 (parity_in_low != odd_par(user_data_in[7:0]) ||
                  parity_in_high != odd_par(user_data_in[15:8]))) begin
      dpe <= 1'b1;
    end else if (srst) begin
      dpe <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cpe <= 1'b0;
    end else if (reg_write && reg_wparity != odd_par(reg_wdata[7:0] ^ reg_wdata[15:8])) begin
      cpe <= 1'b1;
    end else if (srst) begin
      cpe <= 1'b0;
    end
  end

  // ==========================================================
  // registers and read mux
  // ==========================================================
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      out_buf            <= `CPTC_ZERO16;
      out_new            <= 1'b0;
      user_function_bits <= '0;
    end else begin
      out_new <= addr_hit(reg_write, reg_addr, `CPTC_REG_OUTBUF);
      if (srst) begin
        user_function_bits <= '0;
      end else if (addr_hit(reg_write, reg_addr, `CPTC_REG_UFS)) begin
        user_function_bits <= reg_wdata[15:8];
      end
      if (addr_hit(reg_write, reg_addr, `CPTC_REG_OUTBUF)) begin
        out_buf <= reg_wdata;
      end
    end
  end

  // one summary bit per select code; only our own code can ever light
  generate
    for (genvar g = 0; g < 8; g++) begin : g_attn
      assign attn_bits[g] = (unit_select_code == 3'(g)) && (|attention_lines);
    end
  endgenerate

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= `CPTC_ZERO16;
      type_line <= 1'b0;
    end else begin
      type_line <= type_reg_select && DRIVE_TYPE[`CPTC_DT_LINE];
      reg_rdata <= `CPTC_ZERO16;
      if (reg_read) begin
        case (reg_addr)
          `CPTC_REG_CMD:    reg_rdata <= {8'h00, 1'b1, 1'b0, cmd[5:1], go};
          `CPTC_REG_ISTAT:  reg_rdata <= {|attention_lines, user_error, dpe, cpe,
                                          4'h0, !transfer_enable_ctl, 2'b00,
                                          cycle_pend, busy, 3'b000};
          `CPTC_REG_INBUF:  reg_rdata <= in_buf;
          `CPTC_REG_ATTN:   reg_rdata <= {8'h00, attn_bits};
          `CPTC_REG_UFS:    reg_rdata <= {user_function_bits, user_status_bits};
          `CPTC_REG_DTYPE:  reg_rdata <= DRIVE_TYPE;
          `CPTC_REG_OUTBUF: reg_rdata <= out_buf;
          default:          reg_rdata <= `CPTC_ZERO16;
        endcase
      end
    end
  end
endmodule

//--- tb/cptc_top_sva.sv
// assertion checker for the channel port transfer control block
`timescale 1ns/1ps
`include "cptc_params.svh"
module cptc_top_sva #(
  parameter logic [15:0] DRIVE_TYPE = 16'h0015
) (
  input wire logic                    clk_sys,
  input wire logic                    rst_n,
  input wire logic                    bus_init,
  input wire logic                    run,
  input wire logic                    reg_write,
  input wire logic                    reg_read,
  input wire logic [2:0]              reg_addr,
  input wire cptc_pkg::cptc_word_type reg_wdata,
  input wire cptc_pkg::cptc_word_type reg_rdata,
  input wire logic                    type_line,
  input wire logic                    type_reg_select,
  input wire logic [2:0]              unit_select_code,
  input wire logic                    transfer_enable_ctl,
  input wire logic [3:0]              attention_lines,
  input wire cptc_pkg::cptc_word_type user_data_out,
  input wire logic                    user_go,
  input wire logic                    user_read,
  input wire logic                    busy,
  input wire logic                    end_cycle,
  input wire logic                    iface_clear
);
  import cptc_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  wire cmd_go = reg_write && reg_addr == `CPTC_REG_CMD && reg_wdata[0];
  wire cmd_ok = cmd_go && !bus_init
                && (reg_wdata[5:0] == `CPTC_CMD_WRITE || reg_wdata[5:0] == `CPTC_CMD_READ);
  // ==========================================================
  // assertions
  go_pulse_a: assert property (cmd_ok |=> user_go)
    else $error("no go pulse after a valid command");
  go_single_a: assert property (user_go |=> !user_go)
    else $error("go pulse wider than one cycle");
  busy_end_a: assert property (busy |=> !busy && end_cycle)
    else $error("busy not followed by end cycle");
  start_cond_a: assert property ($rose(busy) |-> $past(run) && $past(transfer_enable_ctl))
    else $error("cycle started without run or while ready");
  ready_bit_a: assert property (reg_read && reg_addr == `CPTC_REG_ISTAT |=>
    reg_rdata[`CPTC_BIT_READY] == !$past(transfer_enable_ctl))
    else $error("ready status wrong");
  attn_bit_a: assert property (reg_read && reg_addr == `CPTC_REG_ATTN |=>
    reg_rdata == (16'(|$past(attention_lines)) << $past(unit_select_code)))
    else $error("attention summary wrong");
  type_line_a: assert property (1'b1 |=> type_line == ($past(type_reg_select) & DRIVE_TYPE[2]))
    else $error("drive type line wrong");
  data_hold_a: assert property (!$stable(user_data_out) |->
    ($past(end_cycle) && !$past(end_cycle, 2)) || $past(reg_write, 2))
    else $error("write data changed outside a cycle end");
  clear_hold_a: assert property (iface_clear && !bus_init && !cmd_go |=> iface_clear)
    else $error("interface clear dropped before next command");
  cover property (busy && user_read);
  cover property (busy && !user_read);
  cover property (iface_clear);
endmodule

bind cptc_top cptc_top_sva #(.DRIVE_TYPE(DRIVE_TYPE)) i_cptc_top_sva (.*);

//--- tb/cptc_user_model.sv
// behavioural user device: raises cycle requests and supplies read data
`timescale 1ns/1ps
module cptc_user_model (
  input  wire logic                    clk_sys,
  input  wire logic                    kick,
  input  wire logic                    slow,
  input  wire logic                    bad_par,
  input  wire logic                    sel_b,
  input  wire cptc_pkg::cptc_word_type word,
  input  wire logic                    busy,
  output logic                         cycle_req_a,
  output logic                         cycle_req_b,
  output cptc_pkg::cptc_word_type      user_data_in,
  output logic                         parity_in_low,
  output logic                         parity_in_high
);
  import cptc_pkg::*;
  logic       req;
  logic [3:0] hold;
  // the falling edge asks for a cycle; either line may carry it
  assign cycle_req_a = req && !sel_b;
  assign cycle_req_b = req && sel_b;
  initial begin
    {req, hold, user_data_in, parity_in_low, parity_in_high} = {5'h00, 16'h5A5A, 2'b11};
  end
  always @(posedge clk_sys) begin
    if (kick) begin
      {req, hold, user_data_in} <= {1'b1, slow ? 4'h8 : 4'h2, word};
      parity_in_low <= ~^word[7:0] ^ bad_par;
      parity_in_high <= ~^word[15:8] ^ bad_par;
    end else if (hold != 4'h0) begin
      hold <= hold - 4'h1;
      req <= hold != 4'h1;
    end
    // data no longer held once busy has risen, so show something else
    if (busy) user_data_in <= ~user_data_in;
  end
endmodule

//--- tb/tb_cptc_top.sv
// self-checking bench for the channel port transfer control block
`timescale 1ns/1ps
`include "cptc_params.svh"
`define CHK(g, x) begin n_checks++; if ((g) !== (x)) begin fails++; \
  $display("Error t=%0t got=%h exp=%h", $time, g, x); end end
module tb_cptc_top;
  import cptc_pkg::*;
  logic clk_sys, rst_n, bus_init, run, reg_write, reg_read, reg_wparity, type_line;
  logic type_reg_select, wr_valid, wr_ready, rd_valid, rd_ready, transfer_enable_ctl;
  logic cycle_req_a, cycle_req_b, parity_in_low, parity_in_high, input_parity_inhibit;
  logic user_error, parity_out_low, parity_out_high, user_go, user_read, busy, end_cycle;
  logic iface_clear, kick, slow, bad_par, sel_b, rr;
  logic [2:0] reg_addr, unit_select_code;
  logic [3:0] attention_lines;
  logic [7:0] user_status_bits, user_function_bits, f;
  cptc_word_type reg_wdata, reg_rdata, wr_data, rd_data, user_data_in, user_data_out, word;
  cptc_word_type w[4];
  logic [31:0] q[$];
  logic [31:0] t;
  int fails = 0, n_checks = 0, nb = 0, seed = 85, i;
  cptc_top i_cptc_top (.*);
  cptc_user_model i_cptc_user_model (.*);
  initial begin
    clk_sys = 0;
    forever #50 clk_sys = ~clk_sys;
  end
  // ==========================================================
  // result monitor: register reads and read-fifo words
  always @(posedge clk_sys) rr <= reg_read;
  always @(negedge clk_sys) begin
    if (busy === 1'b1) nb++;
    if (rr === 1'b1 || (rd_valid === 1'b1 && rd_ready === 1'b1)) begin
      t = q.pop_front();
      `CHK((rr ? reg_rdata : rd_data) & t[31:16], t[15:0])
    end
  end
  // ==========================================================
  // bus tasks
  task automatic wreg(input logic [2:0] a, input cptc_word_type d);
    @(posedge clk_sys);
    {reg_write, reg_addr, reg_wdata, reg_wparity} <= {1'b1, a, d, ~^d};
    @(posedge clk_sys);
    reg_write <= 0;
  endtask
  task automatic rreg(input logic [2:0] a, input cptc_word_type m, input cptc_word_type x);
    q.push_back({m, x});
    @(posedge clk_sys);
    {reg_read, reg_addr} <= {1'b1, a};
    @(posedge clk_sys);
    reg_read <= 0;
    repeat (2) @(posedge clk_sys);
  endtask
  task automatic req(input cptc_word_type d, input logic bp);
    @(posedge clk_sys);
    {kick, word, bad_par} <= {1'b1, d, bp};
    @(posedge clk_sys);
    kick <= 0;
  endtask
  task automatic wbusy;
    repeat (30) begin
      @(negedge clk_sys);
      if (busy === 1'b1) break;
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #(5000 * 100);
    fails++;
    close_out;
  end
  initial begin
    {rst_n, bus_init, reg_write, reg_read, reg_wparity, type_reg_select, wr_valid} = 0;
    {rd_ready, input_parity_inhibit, user_error, kick, slow, bad_par, sel_b} = 0;
    {run, transfer_enable_ctl, reg_addr, unit_select_code, attention_lines} = 12'hC00;
    {reg_wdata, wr_data, word, user_status_bits} = 0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1;
    for (i = 0; i < 8; i++) begin
      f = 8'($random(seed));
      @(posedge clk_sys);
      {transfer_enable_ctl, unit_select_code, attention_lines} <= {i[0], i[2:0], f[3:0]};
      {user_status_bits, type_reg_select, user_error} <= {f, f[4], f[5]};
      rreg(`CPTC_REG_ISTAT, 16'h0080, {8'h00, ~i[0], 7'h00});
      rreg(`CPTC_REG_ATTN, 16'hFFFF, 16'(|f[3:0]) << i[2:0]);
      wreg(`CPTC_REG_UFS, {f, 8'h00});
      rreg(`CPTC_REG_UFS, 16'hFFFF, {f, f});
      `CHK(user_function_bits, f)
      `CHK(type_line, f[4])
    end
    rreg(`CPTC_REG_CMD, 16'h0080, 16'h0080);
    $display("test registers done");
    req(16'h1234, 1'b0);
    repeat (10) @(posedge clk_sys);
    `CHK(nb, 0)
    wreg(`CPTC_REG_CMD, {10'h000, `CPTC_CMD_READ});
    @(negedge clk_sys);
    `CHK(user_read, 1'b1)
    `CHK(user_go, 1'b1)
    for (i = 0; i < 4; i++) begin
      w[i] = 16'($random(seed));
      req(w[i], 1'b0);
      wbusy;
    end
    repeat (3) @(posedge clk_sys);
    `CHK(nb, 4)
    rreg(`CPTC_REG_INBUF, 16'hFFFF, w[3]);
    `CHK(rd_valid, 1'b1)
    foreach (w[j]) q.push_back({16'hFFFF, w[j]});
    repeat (30) @(posedge clk_sys) rd_ready <= 1'($random(seed));
    @(posedge clk_sys) rd_ready <= 1;
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys);
    `CHK(rd_valid, 1'b0)
    for (i = 1; i >= 0; i--) begin
      input_parity_inhibit <= i[0];
      w[0] = 16'($random(seed));
      q.push_back({16'hFFFF, w[0]});
      req(w[0], 1'b1);
      wbusy;
      repeat (3) @(posedge clk_sys);
      rreg(`CPTC_REG_ISTAT, 16'h2000, {2'b00, ~i[0], 13'h0000});
    end
    @(posedge clk_sys) run <= 0;
    repeat (2) @(posedge clk_sys);
    rreg(`CPTC_REG_CMD, 16'h0001, 16'h0000);
    run <= 1;
    $display("test read done");
    for (i = 0; i < 4; i++) begin
      w[i] = 16'($random(seed));
      {wr_valid, wr_data} <= {1'b1, w[i]};
      @(posedge clk_sys);
    end
    wr_valid <= 0;
    @(negedge clk_sys);
    `CHK(wr_ready, 1'b0)
    wreg(`CPTC_REG_CMD, {10'h000, `CPTC_CMD_WRITE});
    {sel_b, slow} <= 2'b11;
    req(16'h0000, 1'b0);
    slow <= 0;
    for (i = 0; i < 4; i++) begin
      wbusy;
      if (i < 2) req(16'h0000, 1'b0);
      else if (i == 2) wreg(`CPTC_REG_ISTAT, 16'h0010);
      else repeat (2) @(posedge clk_sys);
      @(negedge clk_sys);
      `CHK(user_data_out, w[i])
      `CHK({parity_out_high, parity_out_low}, {~^w[i][15:8], ~^w[i][7:0]})
      `CHK(end_cycle, 1'b1)
    end
    `CHK(nb, 10)
    $display("test write done");
    @(posedge clk_sys) bus_init <= 1;
    @(posedge clk_sys) bus_init <= 0;
    wreg(`CPTC_REG_CMD, 16'h000B);
    rreg(`CPTC_REG_CMD, 16'h0001, 16'h0001);
    req(16'h0000, 1'b0);
    repeat (10) @(posedge clk_sys);
    `CHK(nb, 10)
    wreg(`CPTC_REG_CMD, {10'h000, `CPTC_CMD_ICLR});
    @(negedge clk_sys);
    `CHK(iface_clear, 1'b1)
    rreg(`CPTC_REG_CMD, 16'h0001, 16'h0001);
    rreg(`CPTC_REG_DTYPE, 16'h0004, 16'h0004);
    wreg(`CPTC_REG_OUTBUF, 16'hC3A5);
    rreg(`CPTC_REG_OUTBUF, 16'hFFFF, 16'hC3A5);
    `CHK(user_data_out, 16'hC3A5)
    $display("test command decode done");
    close_out;
  end
endmodule
